//--- nps_pkg.sv
// Package for the next-PC sequencer: register map, field layout,
// reset values and the structs carried between the stages.
// Assumes a single 100 MHz clock domain and an Avalon-MM master.
package nps_pkg;

  // ==========================================================
  // Core widths, step sizes and fixed addresses
  // ==========================================================
  localparam int NPS_XLEN = 32;
  localparam int NPS_GPR_AW = 5;
  localparam int NPS_PHYS_BITS = 32;
  localparam int NPS_FPR_COUNT = 32;
  localparam logic [31:0] NPS_STEP_SHORT = 32'h0000_0002;
  localparam logic [31:0] NPS_STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] NPS_RESET_PC = 32'hbfc0_0000;
  localparam logic [31:0] NPS_EXC_VECTOR = 32'h8000_0180;

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [5:0] NPS_OFF_CTRL = 6'h00;
  localparam logic [5:0] NPS_OFF_STATE = 6'h04;
  localparam logic [5:0] NPS_OFF_PC = 6'h08;
  localparam logic [5:0] NPS_OFF_EPC = 6'h0c;
  localparam logic [5:0] NPS_OFF_EXC = 6'h10;
  localparam logic [5:0] NPS_OFF_PHYS = 6'h14;
  localparam logic [5:0] NPS_OFF_IRQ_STAT = 6'h18;
  localparam logic [5:0] NPS_OFF_IRQ_EN = 6'h1c;
  localparam logic [5:0] NPS_OFF_IRQ_CLR = 6'h20;

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int NPS_CTRL_FPR_SEL_BIT = 0;
  localparam int NPS_ST_ISA_BIT = 0;
  localparam int NPS_ST_DS_BIT = 1;
  localparam int NPS_ST_FPR_BIT = 2;
  localparam int NPS_ST_PEND_BIT = 3;
  localparam int NPS_EXC_ARG_POS = 8;
  localparam int NPS_IRQ_EXC_BIT = 0;
  localparam int NPS_IRQ_REDIR_BIT = 1;
  localparam int NPS_IRQ_ISA_BIT = 2;
  localparam int NPS_IRQ_W = 3;
  localparam logic NPS_CTRL_FPR_SEL_RST = 1'b0;
  localparam logic [2:0] NPS_IRQ_EN_RST = 3'h0;

  // ==========================================================
  // Carrier types
  // ==========================================================
  typedef struct packed {
    logic valid;
    logic [NPS_GPR_AW-1:0] addr;
    logic [NPS_XLEN-1:0] data;
  } nps_gpr_wr_t;

  typedef struct packed {
    logic raise;
    logic [4:0] kind;
    logic [23:0] arg;
  } nps_exc_t;

  typedef struct packed {
    logic taken;
    logic [NPS_XLEN-1:0] target;
  } nps_branch_t;

endpackage : nps_pkg

//--- nps_late_write.sv
// Holds one delayed register result for one instruction time.
// Assumes step_in marks the boundary between instruction times.
`timescale 1ns/1ps
module nps_late_write
  import nps_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Instruction boundary and capture
  input wire logic step_in,
  input wire logic drop_in,
  input nps_gpr_wr_t late_in,
  // Write issued in the following instruction time
  output nps_gpr_wr_t late_wr_out
);

  // ==========================================================
  // Capture stage
  // ==========================================================
  nps_gpr_wr_t held_q;

  // Result of instruction I held until the next boundary
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      held_q <= '0;
    end else if (step_in) begin
      held_q.valid <= late_in.valid & ~drop_in;
      held_q.addr <= late_in.addr;
      held_q.data <= late_in.data;
    end
  end

  // ==========================================================
  // Issue stage
  // ==========================================================
  // Written together with the next instruction's own effects
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      late_wr_out <= '0;
    end else begin
      late_wr_out.valid <= step_in & held_q.valid;
      late_wr_out.addr <= held_q.addr;
      late_wr_out.data <= held_q.data;
    end
  end

endmodule : nps_late_write

//--- nps_sequencer.sv
// Next-PC sequencer: program counter, instruction-set mode,
// delay-slot tracking, exception capture and register access.
// Assumes fetch/decode logic on the same clock gives one step_in
// pulse per instruction time, with its decode inputs valid then.
// Assumes an Avalon-MM master on this clock, one access at a time.
`timescale 1ns/1ps
module nps_sequencer
  import nps_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Decode side, one instruction time per step
  input wire logic step_in,
  input wire logic insn_is_short_in,
  input nps_branch_t branch_in,
  input wire logic link_in,
  input wire logic [NPS_GPR_AW-1:0] link_addr_in,
  input nps_gpr_wr_t late_in,
  input nps_exc_t exc_in,
  // Fetch side
  output logic [NPS_XLEN-1:0] pc_out,
  output logic [NPS_PHYS_BITS-1:0] phys_addr_out,
  output logic insn_set_select_out,
  output logic in_delay_slot_flag_out,
  output logic fpr_width_mode_out,
  // Register file writes
  output nps_gpr_wr_t link_wr_out,
  output nps_gpr_wr_t late_wr_out,
  // Coprocessor restart value
  output logic epc_wr_out,
  output logic [NPS_XLEN-1:0] epc_out,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Interrupt
  output logic irq_out
);

  // ==========================================================
  // State declarations
  // ==========================================================
  logic [NPS_XLEN-1:0] pc_q;
  logic isa_q;
  logic ds_q;
  logic pend_q;
  logic [NPS_XLEN-1:0] target_q;
  logic [NPS_XLEN-1:0] branch_pc_q;
  logic [NPS_XLEN-1:0] epc_q;
  logic [4:0] exc_kind_q;
  logic [23:0] exc_arg_q;
  logic fpr_width_select_bit_q;
  logic [NPS_IRQ_W-1:0] irq_stat_q;
  logic [NPS_IRQ_W-1:0] irq_en_q;
  logic ack_q;
  logic [31:0] rdata_q;

  logic [NPS_XLEN-1:0] inc_d;
  logic [NPS_XLEN-1:0] seq_pc_d;
  logic [NPS_XLEN-1:0] link_val_d;
  logic [NPS_XLEN-1:0] restart_d;
  logic take_exc;
  logic redirect;
  logic new_branch;
  logic [NPS_IRQ_W-1:0] irq_evt;
  logic bus_req;
  logic wr_fire;
  logic [5:0] wr_addr;
  // Bus decode and read mux
  logic sel_ctrl;
  logic sel_irq_en;
  logic sel_irq_clr;
  logic rd_capture;
  logic [31:0] rdata_d;

  // ==========================================================
  // Next-address arithmetic
  // ==========================================================
  // Size of the instruction at the PC
  assign inc_d = insn_is_short_in ? NPS_STEP_SHORT : NPS_STEP_LONG;
  assign seq_pc_d = pc_q + inc_d;
  // Return point skips branch and its delay slot
  assign link_val_d = seq_pc_d + NPS_STEP_LONG;
  // Slot instructions restart at their branch
  assign restart_d = ds_q ? branch_pc_q : pc_q;

  // Boundary events
  assign take_exc = step_in & exc_in.raise;
  assign redirect = step_in & ~exc_in.raise & pend_q;
  // A branch sitting in a slot is not honoured
  assign new_branch = step_in & ~exc_in.raise & branch_in.taken & ~ds_q;

  // ==========================================================
  // Program counter
  // ==========================================================
  // Exception, delayed target, or plain advance
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_q <= NPS_RESET_PC;
    end else if (take_exc) begin
      pc_q <= NPS_EXC_VECTOR;
    end else if (redirect) begin
      pc_q <= {target_q[NPS_XLEN-1:1], 1'b0};
    end else if (step_in) begin
      pc_q <= seq_pc_d;
    end
  end

  // ==========================================================
  // Instruction-set mode
  // ==========================================================
  // Low target bit picks the mode; exceptions enter long mode
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      isa_q <= 1'b0;
    end else if (take_exc) begin
      isa_q <= 1'b0;
    end else if (redirect) begin
      isa_q <= target_q[0];
    end
  end

  // ==========================================================
  // Branch pending and delay-slot flag
  // ==========================================================
  // Target waits one instruction time for the slot
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_q <= 1'b0;
      target_q <= '0;
      branch_pc_q <= '0;
    end else if (take_exc) begin
      pend_q <= 1'b0;
    end else if (new_branch) begin
      pend_q <= 1'b1;
      target_q <= branch_in.target;
      branch_pc_q <= pc_q;
    end else if (redirect) begin
      pend_q <= 1'b0;
    end
  end

  // Set only for the instruction that follows a taken branch
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ds_q <= 1'b0;
    end else if (step_in) begin
      ds_q <= new_branch;
    end
  end

  // ==========================================================
  // Exception capture
  // ==========================================================
  // Restart value is upper PC bits joined with the mode
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      epc_q <= '0;
      exc_kind_q <= '0;
      exc_arg_q <= '0;
    end else if (take_exc) begin
      epc_q <= {restart_d[NPS_XLEN-1:1], isa_q};
      exc_kind_q <= exc_in.kind;
      exc_arg_q <= exc_in.arg;
    end
  end

  // Coprocessor write strobe in the raising instruction time
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      epc_wr_out <= 1'b0;
    end else begin
      epc_wr_out <= take_exc;
    end
  end

  // ==========================================================
  // Link write
  // ==========================================================
  // Suppressed when the same instruction raises an exception
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_wr_out <= '0;
    end else begin
      link_wr_out.valid <= step_in & link_in & ~exc_in.raise;
      link_wr_out.addr <= link_addr_in;
      link_wr_out.data <= {link_val_d[NPS_XLEN-1:1], isa_q};
    end
  end

  // ==========================================================
  // Delayed results
  // ==========================================================
  // Own-time and next-time writes leave on separate ports
  nps_late_write u_late (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .step_in(step_in),
    .drop_in(exc_in.raise),
    .late_in(late_in),
    .late_wr_out(late_wr_out)
  );

  // ==========================================================
  // Plain outputs
  // ==========================================================
  assign pc_out = pc_q;
  // Address limited to the implemented physical width
  assign phys_addr_out = pc_q[NPS_PHYS_BITS-1:0];
  assign insn_set_select_out = isa_q;
  assign in_delay_slot_flag_out = ds_q;
  assign fpr_width_mode_out = fpr_width_select_bit_q;
  assign epc_out = epc_q;

  // ==========================================================
  // Avalon-MM slave
  // ==========================================================
  // One wait cycle, then the answer
  assign bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign wr_fire = avs_write_in & ack_q & avs_byteenable_in[0];
  assign wr_addr = {avs_address_in[5:2], 2'b00};
  assign avs_readdata_out = rdata_q;

  // Register selects shared by the write paths
  assign sel_ctrl = (wr_addr == NPS_OFF_CTRL);
  assign sel_irq_en = (wr_addr == NPS_OFF_IRQ_EN);
  assign sel_irq_clr = (wr_addr == NPS_OFF_IRQ_CLR);
  // Read data is latched in the waiting cycle
  assign rd_capture = avs_read_in & ~ack_q;

  // Acknowledge toggles once per request
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // ==========================================================
  // Register read path
  // ==========================================================
  // Read mux over the register map; unmapped words read zero
  always_comb begin
    rdata_d = '0;
    if (wr_addr == NPS_OFF_CTRL) begin
      rdata_d[NPS_CTRL_FPR_SEL_BIT] = fpr_width_select_bit_q;
    end else if (wr_addr == NPS_OFF_STATE) begin
      rdata_d[NPS_ST_ISA_BIT] = isa_q;
      rdata_d[NPS_ST_DS_BIT] = ds_q;
      rdata_d[NPS_ST_FPR_BIT] = fpr_width_select_bit_q;
      rdata_d[NPS_ST_PEND_BIT] = pend_q;
    end else if (wr_addr == NPS_OFF_PC) begin
      rdata_d = pc_q;
    end else if (wr_addr == NPS_OFF_EPC) begin
      rdata_d = epc_q;
    end else if (wr_addr == NPS_OFF_EXC) begin
      rdata_d[4:0] = exc_kind_q;
      rdata_d[NPS_EXC_ARG_POS+:24] = exc_arg_q;
    end else if (wr_addr == NPS_OFF_PHYS) begin
      rdata_d = 32'(NPS_PHYS_BITS);
    end else if (wr_addr == NPS_OFF_IRQ_STAT) begin
      rdata_d[NPS_IRQ_W-1:0] = irq_stat_q;
    end else if (wr_addr == NPS_OFF_IRQ_EN) begin
      rdata_d[NPS_IRQ_W-1:0] = irq_en_q;
    end
  end

  // Held from the waiting cycle to the completing edge
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= '0;
    end else if (rd_capture) begin
      rdata_q <= rdata_d;
    end
  end

  // Control register holding the FPR width select bit
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fpr_width_select_bit_q <= NPS_CTRL_FPR_SEL_RST;
    end else if (wr_fire && sel_ctrl) begin
      fpr_width_select_bit_q <= avs_writedata_in[NPS_CTRL_FPR_SEL_BIT];
    end
  end

  // ==========================================================
  // Interrupt status, enable and clear
  // ==========================================================
  // Events that set the sticky status bits
  assign irq_evt[NPS_IRQ_EXC_BIT] = take_exc;
  assign irq_evt[NPS_IRQ_REDIR_BIT] = redirect;
  assign irq_evt[NPS_IRQ_ISA_BIT] = redirect & (target_q[0] != isa_q);

  // Enable mask
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_en_q <= NPS_IRQ_EN_RST;
    end else if (wr_fire && sel_irq_en) begin
      irq_en_q <= avs_writedata_in[NPS_IRQ_W-1:0];
    end
  end

  // Sticky bits; a new event beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NPS_IRQ_W; gi++) begin : g_irq
      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (wr_fire && sel_irq_clr &&
                     avs_writedata_in[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Level output while any enabled bit stands
  assign irq_out = |(irq_stat_q & irq_en_q);

endmodule : nps_sequencer

//--- nps_seq_assertions.sv
// Concurrent checks on the next-PC sequencer ports.
// Assumes binding onto nps_sequencer, single clock domain.
`timescale 1ns/1ps
module nps_seq_assertions
  import nps_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Decode side
  input wire logic step_in,
  input wire logic insn_is_short_in,
  input nps_branch_t branch_in,
  input wire logic link_in,
  input wire logic [NPS_GPR_AW-1:0] link_addr_in,
  input nps_gpr_wr_t late_in,
  input nps_exc_t exc_in,
  // Sequencer outputs
  input wire logic [NPS_XLEN-1:0] pc_out,
  input wire logic [NPS_PHYS_BITS-1:0] phys_addr_out,
  input wire logic insn_set_select_out,
  input wire logic in_delay_slot_flag_out,
  input wire logic fpr_width_mode_out,
  input nps_gpr_wr_t link_wr_out,
  input nps_gpr_wr_t late_wr_out,
  input wire logic epc_wr_out,
  input wire logic [NPS_XLEN-1:0] epc_out,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out
);
  // ==========================================================
  // Helper state
  // ==========================================================
  logic go_w;
  logic [30:0] ret_w, rpc_w;
  logic [31:0] tgt_q, bpc_q;
  nps_gpr_wr_t lq_q;
  // Step without exception, link and restart values
  assign go_w = step_in && !exc_in.raise;
  assign ret_w = pc_out[31:1] + (insn_is_short_in ? 31'h1 : 31'h2) + 31'h2;
  assign rpc_w = in_delay_slot_flag_out ? bpc_q[31:1] : pc_out[31:1];
  // Open branch target and branch address
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tgt_q <= 32'h0;
      bpc_q <= 32'h0;
    end else if (go_w && branch_in.taken && !in_delay_slot_flag_out) begin
      tgt_q <= branch_in.target;
      bpc_q <= pc_out;
    end
  end
  // Delayed result waiting for the next step
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) lq_q <= '0;
    else if (step_in) lq_q <= exc_in.raise ? '0 : late_in;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================
  // Properties
  // ==========================================================
  a_pc_advance: assert property (
    go_w && !in_delay_slot_flag_out |=> pc_out == $past(pc_out) +
      ($past(insn_is_short_in) ? NPS_STEP_SHORT : NPS_STEP_LONG))
    else $error("pc step size wrong");
  a_flag_set: assert property (
    go_w && !in_delay_slot_flag_out |=> in_delay_slot_flag_out == $past(branch_in.taken))
    else $error("delay slot flag wrong");
  a_slot_redirect: assert property (
    go_w && in_delay_slot_flag_out |=> pc_out == {tgt_q[31:1], 1'b0} &&
      insn_set_select_out == tgt_q[0] && !in_delay_slot_flag_out)
    else $error("redirect after slot wrong");
  a_link_value: assert property (
    go_w && link_in |=> link_wr_out.valid && link_wr_out.addr == $past(link_addr_in) &&
      link_wr_out.data == {$past(ret_w), $past(insn_set_select_out)})
    else $error("link write wrong");
  a_exc_vector: assert property (
    step_in && exc_in.raise |=> pc_out == NPS_EXC_VECTOR && !insn_set_select_out &&
      !in_delay_slot_flag_out && epc_wr_out && !link_wr_out.valid)
    else $error("exception entry wrong");
  a_epc_value: assert property (
    step_in && exc_in.raise |=> epc_out == {$past(rpc_w), $past(insn_set_select_out)})
    else $error("restart value wrong");
  a_late_write: assert property (
    go_w && lq_q.valid |=> late_wr_out == $past(lq_q))
    else $error("late write missing");
  a_late_timing: assert property (
    late_wr_out.valid |-> $past(step_in) && $past(lq_q.valid))
    else $error("late write at wrong time");
  a_fpr_write: assert property (
    avs_write_in && !avs_waitrequest_out && avs_address_in == NPS_OFF_CTRL &&
      avs_byteenable_in[0] |=> fpr_width_mode_out == $past(avs_writedata_in[0]))
    else $error("fpr width mode wrong");
  a_phys_map: assert property (
    phys_addr_out == pc_out[NPS_PHYS_BITS-1:0])
    else $error("physical address wrong");
  c_redirect: cover property (go_w && in_delay_slot_flag_out);
  c_exception: cover property (step_in && exc_in.raise);
  c_late: cover property (late_wr_out.valid);
endmodule : nps_seq_assertions

bind nps_sequencer nps_seq_assertions u_chk (.*);

//--- nps_regfile_model.sv
// Register file and coprocessor model on the sequencer's far side.
// Assumes one-cycle write pulses on the core clock.
`timescale 1ns/1ps
module nps_regfile_model
  import nps_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Writes from the sequencer
  input nps_gpr_wr_t link_wr_in,
  input nps_gpr_wr_t late_wr_in,
  input wire logic epc_wr_in,
  input wire logic [NPS_XLEN-1:0] epc_in,
  // Saved restart value
  output logic [NPS_XLEN-1:0] epc_save_out
);
  logic [NPS_XLEN-1:0] gpr_q [32];
  // Older delayed result lands first, link write after it
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 32; i++) gpr_q[i] <= 32'h0;
    end else begin
      if (late_wr_in.valid) gpr_q[late_wr_in.addr] <= late_wr_in.data;
      if (link_wr_in.valid) gpr_q[link_wr_in.addr] <= link_wr_in.data;
    end
  end
  // Coprocessor restart register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) epc_save_out <= 32'h0;
    else if (epc_wr_in) epc_save_out <= epc_in;
  end
endmodule : nps_regfile_model

//--- next_pc_sequencer_tb_top.sv
// Self-checking bench for the next-PC sequencer.
// Assumes nps_pkg, the checker and the register file model.
`timescale 1ns/1ps
module next_pc_sequencer_tb_top
  import nps_pkg::*;
;
  typedef struct packed {
    logic sh;
    logic tk;
    logic [31:0] tgt;
    logic lk;
    logic [31:0] pc;
    logic fl;
    logic md;
  } nps_row_t;
  logic sys_clk_in, reset_n_in, step_in, insn_is_short_in, link_in, irq_out;
  logic [4:0] link_addr_in;
  nps_branch_t branch_in;
  nps_gpr_wr_t late_in, link_wr_out, late_wr_out;
  nps_exc_t exc_in;
  logic [31:0] pc_out, phys_addr_out, epc_out, epc_save, rd;
  logic insn_set_select_out, in_delay_slot_flag_out, fpr_width_mode_out, epc_wr_out;
  logic [5:0] avs_address_in;
  logic avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in;
  int bad_count, checks_done;
  // Short, taken, target, link, then pc, flag and mode after the step
  nps_row_t rows [10] = '{
    '{1'b0, 1'b0, 32'h0, 1'b0, 32'hbfc0_0004, 1'b0, 1'b0},
    '{1'b1, 1'b0, 32'h0, 1'b0, 32'hbfc0_0006, 1'b0, 1'b0},
    '{1'b0, 1'b1, 32'h0000_1001, 1'b1, 32'hbfc0_000a, 1'b1, 1'b0},
    '{1'b0, 1'b1, 32'h0000_2000, 1'b0, 32'h0000_1000, 1'b0, 1'b1},
    '{1'b1, 1'b0, 32'h0, 1'b0, 32'h0000_1002, 1'b0, 1'b1},
    '{1'b1, 1'b1, 32'h0000_4000, 1'b0, 32'h0000_1004, 1'b1, 1'b1},
    '{1'b0, 1'b0, 32'h0, 1'b0, 32'h0000_4000, 1'b0, 1'b0},
    '{1'b0, 1'b1, 32'h0000_4004, 1'b0, 32'h0000_4004, 1'b1, 1'b0},
    '{1'b0, 1'b0, 32'h0, 1'b0, 32'h0000_4004, 1'b0, 1'b0},
    '{1'b0, 1'b0, 32'h0, 1'b0, 32'h0000_4008, 1'b0, 1'b0}};
  // ==========================================================
  // Design and far side
  // ==========================================================
  nps_sequencer u_dut (.*);
  nps_regfile_model u_rf (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .link_wr_in(link_wr_out),
    .late_wr_in(late_wr_out),
    .epc_wr_in(epc_wr_out),
    .epc_in(epc_out),
    .epc_save_out(epc_save)
  );
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic step(input logic sh, input logic tk, input logic [31:0] tg, input logic lk);
    insn_is_short_in <= sh;
    branch_in <= '{tk, tg};
    link_in <= lk;
    step_in <= 1'b1;
    @(posedge sys_clk_in);
    step_in <= 1'b0;
    link_in <= 1'b0;
    branch_in <= '0;
    late_in <= '0;
    exc_in <= '0;
    @(posedge sys_clk_in);
  endtask : step
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge sys_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : bus
  // Clock and watchdog
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #200us;
    bad_count++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {reset_n_in, step_in, insn_is_short_in, link_in, link_addr_in} = '0;
    {branch_in, late_in, exc_in} = '0;
    {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
    avs_byteenable_in = 4'hf;
    repeat (20) @(posedge sys_clk_in);
    chk(pc_out, NPS_RESET_PC);
    chk(irq_out, 1'b0);
    reset_n_in <= 1'b1;
    link_addr_in <= 5'h1f;
    foreach (rows[i]) begin
      step(rows[i].sh, rows[i].tk, rows[i].tgt, rows[i].lk);
      chk(pc_out, rows[i].pc);
      chk(in_delay_slot_flag_out, rows[i].fl);
      chk(insn_set_select_out, rows[i].md);
    end
    chk(u_rf.gpr_q[31], 32'hbfc0_000e);
    // Delayed result lands one instruction later
    late_in <= '{1'b1, 5'h03, 32'h1234_5678};
    step(1'b0, 1'b0, 32'h0, 1'b0);
    chk(u_rf.gpr_q[3], 32'h0);
    step(1'b0, 1'b0, 32'h0, 1'b0);
    @(posedge sys_clk_in);
    chk(u_rf.gpr_q[3], 32'h1234_5678);
    // Exception in a delay slot drops link and late writes
    step(1'b0, 1'b1, 32'h0000_5000, 1'b0);
    link_addr_in <= 5'h07;
    late_in <= '{1'b1, 5'h09, 32'hffff_0000};
    exc_in <= '{1'b1, 5'h04, 24'h00abcd};
    step(1'b0, 1'b0, 32'h0, 1'b1);
    chk(pc_out, NPS_EXC_VECTOR);
    chk(in_delay_slot_flag_out, 1'b0);
    chk(epc_out, 32'h0000_4010);
    step(1'b0, 1'b0, 32'h0, 1'b0);
    chk(pc_out, 32'h8000_0184);
    chk(u_rf.gpr_q[7], 32'h0);
    chk(u_rf.gpr_q[9], 32'h0);
    chk(epc_save, 32'h0000_4010);
    // Registers and interrupt
    bus(1'b0, NPS_OFF_EXC, 32'h0);
    chk(rd, 32'h00ab_cd04);
    bus(1'b0, NPS_OFF_PC, 32'h0);
    chk(rd, 32'h8000_0184);
    chk(phys_addr_out, 32'h8000_0184);
    bus(1'b0, NPS_OFF_PHYS, 32'h0);
    chk(rd, 32'h0000_0020);
    bus(1'b0, 6'h3c, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, NPS_OFF_IRQ_EN, 32'h0);
    chk(rd, 32'h0);
    chk(irq_out, 1'b0);
    bus(1'b0, NPS_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0000_0007);
    bus(1'b1, NPS_OFF_IRQ_EN, 32'h1);
    chk(irq_out, 1'b1);
    bus(1'b1, NPS_OFF_IRQ_CLR, 32'h7);
    chk(irq_out, 1'b0);
    bus(1'b0, NPS_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, NPS_OFF_CTRL, 32'h1);
    chk(fpr_width_mode_out, 1'b1);
    bus(1'b0, NPS_OFF_STATE, 32'h0);
    chk(rd[NPS_ST_FPR_BIT], 1'b1);
    // Reset in mid-run restores the start state
    reset_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk(pc_out, NPS_RESET_PC);
    chk(fpr_width_mode_out, 1'b0);
    chk(irq_out, 1'b0);
    reset_n_in <= 1'b1;
    step(1'b1, 1'b0, 32'h0, 1'b0);
    chk(pc_out, 32'hbfc0_0002);
    conclude();
  end
endmodule : next_pc_sequencer_tb_top
